// ---- hw/mmd_pkg.sv ----
// Constants for the memory map and register file decoder.
// Assumes one clock and reset from the core; addresses are byte addresses, widths are in bits.
package mmd_pkg;
  localparam int PM_ADDR_W = 16;
  localparam int PM_SIZE = 8192;
  localparam int PM_ROM_W = 13;
  localparam logic [15:0] PM_VEC_END = 16'h00ff;
  localparam logic [15:0] PM_RSV_LO = 16'h003c;
  localparam logic [15:0] PM_RSV_HI = 16'h003d;
  localparam logic [15:0] PM_OPT_LO = 16'h003e;
  localparam logic [15:0] PM_OPT_HI = 16'h003f;
  localparam logic [15:0] PM_RESET_ADDR = 16'h0100;

  localparam int RF_DATA_W = 8;
  localparam int RF_PHYS_W = 9;
  localparam int RF_DEPTH = 352;
  localparam logic [7:0] RF_SET1_BASE = 8'hc0;
  localparam logic [7:0] RF_BANK_BASE = 8'he0;
  localparam logic [7:0] RF_PP_ADDR = 8'hdf;
  localparam logic [7:0] PP_RESET = 8'h00;
  localparam logic [8:0] PH_SET2 = 9'h0c0;
  localparam logic [8:0] PH_SET1 = 9'h100;
  localparam logic [8:0] PH_BANK0 = 9'h120;
  localparam logic [8:0] PH_BANK1 = 9'h140;

  typedef enum logic [1:0] {
    AM_REG,
    AM_WORK,
    AM_INDIRECT,
    AM_INDEXED
  } mmd_amode_t;
endpackage : mmd_pkg

// ---- hw/mmd_mem_if.sv ----
// Carrier between the decoder and its register storage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface mmd_mem_if;
  import mmd_pkg::*;
  logic [RF_PHYS_W-1:0] addr;
  logic [RF_DATA_W-1:0] wdata;
  logic we;
  logic [RF_DATA_W-1:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface : mmd_mem_if

// ---- hw/mmd_regmem.sv ----
// Physical register storage, one byte per location, registered read data.
// Assumes a decoded physical address below DEPTH.
`timescale 1ns/1ns
module mmd_regmem
  import mmd_pkg::*;
#(
  parameter int DEPTH = RF_DEPTH
) (
  // Clock
  input wire logic sys_clk,
  // Storage port
  mmd_mem_if.mem port
);
  if (DEPTH > (1 << RF_PHYS_W) || DEPTH < 1) begin : g_chk
    $error("mmd_regmem: DEPTH out of range");
  end

  logic [RF_DATA_W-1:0] mem_q [DEPTH];
  logic [RF_DATA_W-1:0] rdata_q;

  // Storage is not reset; software initialises what it uses
  always_ff @(posedge sys_clk) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    rdata_q <= mem_q[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule : mmd_regmem

// ---- hw/mmd_decode.sv ----
// Program memory and register file address decoder with page and bank state.
// Assumes the core drives one register request per cycle at most and
// holds pm_addr/reg_addr valid in the cycle of its strobe.
`timescale 1ns/1ns
module mmd_decode
  import mmd_pkg::*;
#(
  parameter int PM_BYTES = PM_SIZE,
  parameter int RF_LOCS = RF_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Program memory request
  input wire logic [PM_ADDR_W-1:0] pm_addr,
  input wire logic pm_rd,
  // Program memory decode
  output logic [PM_ROM_W-1:0] pm_rom_addr_q,
  output logic pm_rom_en_q,
  output logic pm_vector_q,
  output logic pm_option_q,
  output logic pm_reserved_q,
  output logic pm_out_of_range_q,
  output logic [PM_ADDR_W-1:0] reset_fetch_addr_q,
  // Register bus request
  input wire logic [7:0] reg_addr,
  input wire logic [RF_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_mode,
  input wire logic select_bank_zero_op,
  input wire logic select_bank_one_op,
  // Register bus answer and state
  output logic [RF_DATA_W-1:0] reg_rdata_q,
  output logic reg_rvalid_q,
  output logic [7:0] register_page_pointer_q,
  output logic bank_sel_q,
  output logic set2_hit_q
);
  if (PM_BYTES != (1 << PM_ROM_W) || RF_LOCS != RF_DEPTH) begin : g_chk
    $error("mmd_decode: sizes do not match the decoder");
  end

  mmd_mem_if mif ();
  mmd_regmem #(.DEPTH(RF_LOCS)) u_mem (
    .sys_clk(sys_clk),
    .port(mif.mem)
  );

  logic upper;
  logic via_ptr;
  logic to_set2;
  logic pp_hit;
  logic [RF_PHYS_W-1:0] phys;
  logic rd_pend_q;
  logic rd_pp_q;
  logic [7:0] pp_snap_q;

  // Register address decode
  always_comb begin
    upper = reg_addr >= RF_SET1_BASE;
    via_ptr = (reg_mode == AM_INDIRECT) || (reg_mode == AM_INDEXED);
    to_set2 = upper && via_ptr;
    pp_hit = upper && !via_ptr && (reg_addr == RF_PP_ADDR);
    // Page pointer is not looked at: only page 0 exists, so every page folds there
    if (!upper) begin
      phys = {1'b0, reg_addr};
    end else if (to_set2) begin
      phys = PH_SET2 + {3'h0, reg_addr[5:0]};
    end else if (reg_addr < RF_BANK_BASE) begin
      phys = PH_SET1 + {4'h0, reg_addr[4:0]};
    end else if (bank_sel_q) begin
      phys = PH_BANK1 + {4'h0, reg_addr[4:0]};
    end else begin
      phys = PH_BANK0 + {4'h0, reg_addr[4:0]};
    end
  end

  // Page pointer lives in a flop, not storage, so its reset value is defined
  assign mif.addr = phys;
  assign mif.wdata = reg_wdata;
  assign mif.we = reg_wr && !pp_hit;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      register_page_pointer_q <= PP_RESET;
    end else if (reg_wr && pp_hit) begin
      register_page_pointer_q <= reg_wdata;
    end
  end

  // Bank zero wins if both ops arrive together
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bank_sel_q <= 1'b0;
    end else if (select_bank_zero_op) begin
      bank_sel_q <= 1'b0;
    end else if (select_bank_one_op) begin
      bank_sel_q <= 1'b1;
    end
  end

  // Read path: storage register, then output register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      rd_pp_q <= 1'b0;
      pp_snap_q <= PP_RESET;
      reg_rvalid_q <= 1'b0;
      reg_rdata_q <= 8'h00;
      set2_hit_q <= 1'b0;
    end else begin
      rd_pend_q <= reg_rd;
      rd_pp_q <= reg_rd && pp_hit;
      pp_snap_q <= register_page_pointer_q;
      reg_rvalid_q <= rd_pend_q;
      if (rd_pend_q) begin
        reg_rdata_q <= rd_pp_q ? pp_snap_q : mif.rdata;
      end
      if (reg_rd || reg_wr) begin
        set2_hit_q <= to_set2;
      end
    end
  end

  // Program memory decode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pm_rom_addr_q <= 13'h0000;
      pm_rom_en_q <= 1'b0;
      pm_vector_q <= 1'b0;
      pm_option_q <= 1'b0;
      pm_reserved_q <= 1'b0;
      pm_out_of_range_q <= 1'b0;
    end else begin
      pm_rom_addr_q <= pm_addr[PM_ROM_W-1:0];
      pm_rom_en_q <= pm_rd && (pm_addr[PM_ADDR_W-1:PM_ROM_W] == 3'h0);
      pm_out_of_range_q <= pm_rd && (pm_addr[PM_ADDR_W-1:PM_ROM_W] != 3'h0);
      // Vector area still reads as ordinary memory
      pm_vector_q <= pm_rd && (pm_addr <= PM_VEC_END);
      pm_option_q <= pm_rd && (pm_addr == PM_OPT_LO || pm_addr == PM_OPT_HI);
      pm_reserved_q <= pm_rd && (pm_addr == PM_RSV_LO || pm_addr == PM_RSV_HI);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reset_fetch_addr_q <= PM_RESET_ADDR;
    end else begin
      reset_fetch_addr_q <= PM_RESET_ADDR;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_pp_write_lands: assert property (reg_wr && pp_hit |=> register_page_pointer_q == $past(reg_wdata))
    else $error("page pointer write lost");
  a_pp_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0)
    $past(rst) && rst |-> register_page_pointer_q == 8'h00)
    else $error("page pointer not cleared by reset");
  a_bank_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0)
    $past(rst) && rst |-> !bank_sel_q)
    else $error("bank not zero in reset");
  a_bank_select_op: assert property (select_bank_one_op && !select_bank_zero_op ##1 !select_bank_zero_op
    |-> bank_sel_q)
    else $error("bank one select lost");
  // Back to back reads are legal, so an answer may already stand when a read is taken
  a_read_two_cycles: assert property (reg_rd |-> ##2 reg_rvalid_q)
    else $error("read answer not two cycles later");
  a_read_no_spurious: assert property (!reg_rd |-> ##2 !reg_rvalid_q)
    else $error("read answer without a read");
  a_rdata_hold: assert property (!rd_pend_q |=> $stable(reg_rdata_q))
    else $error("read data moved without an answer");
  a_set2_route_only: assert property (reg_rd && reg_addr >= 8'hc0 |=>
    set2_hit_q == ($past(reg_mode) == AM_INDIRECT || $past(reg_mode) == AM_INDEXED))
    else $error("set 2 routing wrong");
  a_set2_flag_hold: assert property (!(reg_rd || reg_wr) |=> $stable(set2_hit_q))
    else $error("set 2 flag moved without an access");
  a_pm_option_bytes: assert property (pm_rd && pm_addr[15:1] == 15'h001f |=> pm_option_q && pm_rom_en_q)
    else $error("option byte not flagged");
  a_pm_vector_area: assert property (pm_rd && pm_addr < 16'h0100 |=> pm_vector_q && pm_rom_en_q)
    else $error("vector area not ordinary memory");
  a_pm_range_limit: assert property (pm_rd && pm_addr >= 16'h2000 |=> pm_out_of_range_q && !pm_rom_en_q)
    else $error("address beyond 8K enabled");
  a_reset_fetch_addr: assert property (##1 reset_fetch_addr_q == 16'h0100)
    else $error("reset fetch address wrong");
  a_pm_reserved_bytes: assert property (pm_rd && pm_addr[15:1] == 15'h001e |=>
    pm_reserved_q && !pm_option_q && pm_rom_en_q)
    else $error("reserved byte not flagged");
  a_pm_idle_quiet: assert property (!pm_rd |=> !pm_rom_en_q && !pm_out_of_range_q)
    else $error("program enable without a fetch");
  a_pm_rom_follow: assert property (1'b1 |=> pm_rom_addr_q == $past(pm_addr[PM_ROM_W-1:0]))
    else $error("rom address does not follow fetch address");

  // Storage routing; the page pointer never enters it, since only page 0 exists
  a_prime_page_free: assert property ((reg_rd || reg_wr) && reg_addr < 8'hc0 |->
    mif.addr == {1'b0, reg_addr})
    else $error("prime access not on page 0 storage");
  a_set2_physical: assert property ((reg_rd || reg_wr) && reg_addr >= 8'hc0 && via_ptr |->
    mif.addr == {3'h3, reg_addr[5:0]})
    else $error("set 2 access not in set 2 storage");
  a_set1_common_map: assert property ((reg_rd || reg_wr) && !via_ptr && reg_addr >= 8'hc0 &&
    reg_addr < 8'he0 |-> mif.addr == {4'h8, reg_addr[4:0]})
    else $error("set 1 common access misrouted");
  a_bank_map: assert property ((reg_rd || reg_wr) && !via_ptr && reg_addr >= 8'he0 |->
    mif.addr == (bank_sel_q ? {4'ha, reg_addr[4:0]} : {4'h9, reg_addr[4:0]}))
    else $error("banked access in wrong bank");
  a_map_in_depth: assert property ((reg_rd || reg_wr) |-> {23'h0, mif.addr} < RF_LOCS)
    else $error("decoded location beyond storage");
  a_pp_no_storage: assert property (reg_wr && pp_hit |-> !mif.we)
    else $error("page pointer write reached storage");
  a_pp_holds: assert property (!(reg_wr && pp_hit) |=> $stable(register_page_pointer_q))
    else $error("page pointer moved without a write");
  a_bank_zero_wins: assert property (select_bank_zero_op |=> !bank_sel_q)
    else $error("bank zero select lost");
  a_bank_holds: assert property (!select_bank_zero_op && !select_bank_one_op |=> $stable(bank_sel_q))
    else $error("bank moved without a select op");

  c_pp_write: cover property (reg_wr && pp_hit);
  c_pp_read: cover property (reg_rd && pp_hit ##2 reg_rvalid_q);
  c_set2_read: cover property (reg_rd && to_set2 ##2 reg_rvalid_q);
  c_bank1_read: cover property (bank_sel_q && reg_rd && reg_addr >= 8'he0 && !via_ptr);
  c_option_read: cover property (pm_rd && pm_addr == 16'h003e);
endmodule : mmd_decode

// ---- testbench/mmd_core_model.sv ----
// Core-side driver for the decoder request ports.
// Assumes requests are taken on the rising edge of sys_clk.
`timescale 1ns/1ns
module mmd_core_model (
  // Clock
  input wire logic sys_clk,
  // Requests
  output logic [15:0] pm_addr,
  output logic pm_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [1:0] reg_mode,
  output logic [3:0] strb
);
  initial begin
    {pm_addr, pm_rd, reg_addr, reg_wdata, reg_mode, strb} = '0;
  end
  // Launched just after the edge and held a full cycle, so the taking edge never races
  task drive(input logic [15:0] p, input logic pr, input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] m, input logic [3:0] s);
    @(posedge sys_clk);
    #2;
    {pm_addr, pm_rd, reg_addr, reg_wdata, reg_mode, strb} = {p, pr, a, d, m, s};
  endtask : drive
endmodule : mmd_core_model

// ---- testbench/memory_map_register_decode_test.sv ----
// Self-checking bench comparing the decoder with a byte-array model.
// Assumes register storage sits inside the decoder.
`timescale 1ns/1ns
module memory_map_register_decode_test;
  import mmd_pkg::*;
  logic sys_clk, rst, pm_rd, pm_en, pm_vec, pm_opt, pm_rsv, pm_oor, rvalid, bank, s2, s2_e;
  logic [15:0] pm_addr, rfa;
  logic [7:0] reg_addr, reg_wdata, rdata, pp;
  logic [1:0] reg_mode;
  logic [3:0] strb;
  logic [12:0] rom;
  logic [17:0] pm_e;
  int mem[352];
  int rq[$], rt[$];
  int pv[10] = '{0, 'h3c, 'h3d, 'h3e, 'h3f, 'hff, 'h100, 'h1fff, 'h2000, 'hffff};
  int pp_m, bk_m, cnt = 0, seed = 7, miscompares = 0, n_checks = 0, s2_due = -1, pm_due = -1;
  mmd_core_model u_mmd_core_model (.sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_mode(reg_mode), .strb(strb));
  mmd_decode u_mmd_decode (.sys_clk(sys_clk), .rst(rst), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rom_addr_q(rom), .pm_rom_en_q(pm_en), .pm_vector_q(pm_vec), .pm_option_q(pm_opt),
    .pm_reserved_q(pm_rsv), .pm_out_of_range_q(pm_oor), .reset_fetch_addr_q(rfa),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(strb[3]), .reg_rd(strb[2]),
    .reg_mode(reg_mode), .select_bank_zero_op(strb[1]), .select_bank_one_op(strb[0]),
    .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .register_page_pointer_q(pp),
    .bank_sel_q(bank), .set2_hit_q(s2));
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task final_report;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  function automatic int phys(int a, int m);
    if (a < 'hc0 || m >= 2) return a;
    return a + 'h40 + ((a >= 'he0 && bk_m != 0) ? 'h20 : 0);
  endfunction : phys
  // w: 1 write, 0 read, 2 idle; ops bit 1 bank zero, bit 0 bank one
  task acc(input int w, input int a, input int m, input int ops);
    int d;
    int ph;
    d = $random(seed) & 'hff;
    ph = phys(a, m);
    u_mmd_core_model.drive(16'($random(seed)), 1'b0, 8'(a), 8'(d), 2'(m), {w == 1, w == 0, 2'(ops)});
    if (w < 2) begin
      s2_due = cnt + 1;
      s2_e = a >= 'hc0 && m >= 2;
    end
    if (w == 1 && ph == 'h11f) pp_m = d;
    else if (w == 1) mem[ph] = d;
    if (w == 0) begin
      rq.push_back(ph == 'h11f ? pp_m : mem[ph]);
      rt.push_back(cnt + 2);
    end
    if (ops[1]) bk_m = 0;
    else if (ops[0]) bk_m = 1;
  endtask : acc
  task pm(input int p);
    u_mmd_core_model.drive(16'(p), 1'b1, 8'h00, 8'h00, 2'h0, 4'h0);
    pm_due = cnt + 1;
    pm_e = {p < 'h2000, p < 'h100, p == 'h3e || p == 'h3f, p == 'h3c || p == 'h3d, p >= 'h2000, 13'(p)};
  endtask : pm
  task do_reset;
    rst = 1;
    pp_m = 0;
    bk_m = 0;
    repeat (2) @(posedge sys_clk);
    #2;
    rst = 0;
  endtask : do_reset
  always @(posedge sys_clk) begin
    cnt++;
    #1;
    if (cnt == s2_due) chk(s2, s2_e);
    if (cnt == pm_due) chk({pm_en, pm_vec, pm_opt, pm_rsv, pm_oor, rom}, pm_e);
    if (rvalid) begin
      chk(cnt, rt.pop_front());
      chk(rdata, rq.pop_front());
    end
    chk(rfa, 16'h0100);
    chk(pp, pp_m);
    chk(bank, bk_m);
  end
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Whole run is about 2070 cycles; allow well over twice that
  initial begin
    #500000;
    miscompares++;
    final_report();
  end
  initial begin
    do_reset();
    for (int b = 0; b < 2; b++) begin
      acc(2, 0, 0, b ? 1 : 2);
      for (int a = 0; a < 256; a++) begin
        acc(1, a, 0, 0);
        acc(1, a, 2, 0);
      end
    end
    // Random mix: nonzero page values and colliding bank ops included
    repeat (1000) acc(($random(seed) & 3) == 0, $random(seed) & 'hff, $random(seed) & 3, $random(seed) & 3);
    foreach (pv[i]) pm(pv[i]);
    repeat (20) pm($random(seed) & 'h3fff);
    acc(1, 'hdf, 0, 1);
    acc(2, 0, 0, 0);
    do_reset();
    acc(0, 5, 0, 0);
    repeat (3) acc(2, 0, 0, 0);
    chk(rq.size(), 0);
    final_report();
  end
endmodule : memory_map_register_decode_test
